/* hw/rrm_pkg.sv */
/*
  Package of the refresh-rate mode logic: command bus carrier, mode
  register fields, refresh timings, software register map and reset values.
  Assumes a 10 MHz core clock; the command bus runs on that same clock.
*/
package rrm_pkg;

  // ==========================================================
  // command bus
  typedef struct packed {
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        bg1;
    logic        refresh_rate_select_bit;
    logic [1:0]  ba;
    logic [13:0] addr;
  } rrm_cmd_s;

  typedef enum logic [1:0] {
    RRM_REF_1X = 2'h0,
    RRM_REF_2X = 2'h1,
    RRM_REF_4X = 2'h2
  } rrm_ref_type_e;

  typedef enum logic [1:0] {
    RRM_ST_IDLE = 2'h1,
    RRM_ST_BUSY = 2'h2
  } rrm_state_e;

  // ==========================================================
  // mode registers, selected by {rate select bit, ba}
  localparam logic [2:0] MR_SEL_GRAN   = 3'h3;
  localparam logic [2:0] MR_SEL_TEMP   = 3'h4;
  localparam int         TCOMP_EN_BIT  = 3;
  localparam int         TCOMP_EXT_BIT = 2;
  localparam int         GRAN_LSB     = 6;
  localparam logic [2:0] GRAN_RESET   = 3'h0;
  localparam logic [2:0] GRAN_FIX1    = 3'h0;
  localparam logic [2:0] GRAN_FIX2    = 3'h1;
  localparam logic [2:0] GRAN_FIX4    = 3'h2;
  localparam logic [2:0] GRAN_DYN12   = 3'h5;
  localparam logic [2:0] GRAN_DYN14   = 3'h6;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int RFC1_NS        = 350;
  localparam int RFC2_NS        = 260;
  localparam int RFC4_NS        = 160;
  localparam logic [3:0] RFC1_CYC = 4'((RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RFC2_CYC = 4'((RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] RFC4_CYC = 4'((RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] REFI_BASE_NS = 16'h1e78;  // 7800 ns
  localparam logic [15:0] REFI_EXT_NS  = 16'h0f3c;  // 3900 ns
  localparam logic signed [7:0] TEMP_COLD_C = 8'sh2d;  // 45 C
  localparam logic signed [7:0] TEMP_HOT_C  = 8'sh55;  // 85 C

  // ==========================================================
  // software registers (APB byte addresses)
  localparam logic [7:0]  OFS_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_TEMP     = 8'h04;
  localparam logic [7:0]  OFS_FLAGS    = 8'h08;
  localparam logic [7:0]  OFS_COUNT    = 8'h0c;
  localparam logic [7:0]  OFS_INTERVAL = 8'h10;
  localparam logic [7:0]  TEMP_RESET   = 8'h19;
  localparam int FLG_BUSY_VIOL = 0;
  localparam int FLG_RESERVED  = 1;
  localparam int FLG_TCOMP_CONF = 2;

endpackage

/* hw/rrm_cmd_decode.sv */
/*
  Command decoder: classifies one command bus word as mode register
  write or refresh and extracts the fields the mode logic needs.
  Assumes the command word is already in the core clock domain.
*/
`timescale 1ns/1ps
module rrm_cmd_decode (
  input  wire rrm_pkg::rrm_cmd_s cmd_i,
  output logic                   is_mrw_o,
  output logic                   is_ref_o,
  output logic [2:0]             mr_sel_o,
  output logic                   rate_sel_o
);
  import rrm_pkg::*;

  logic base;

  always_comb begin
    base       = !cmd_i.cs_n && cmd_i.act_n && !cmd_i.ras_n && !cmd_i.cas_n;
    is_mrw_o   = base && !cmd_i.we_n;
    is_ref_o   = base && cmd_i.we_n;
    mr_sel_o   = {cmd_i.refresh_rate_select_bit, cmd_i.ba};
    rate_sel_o = cmd_i.refresh_rate_select_bit;
  end

endmodule

/* hw/rrm_top.sv */
/*
  Refresh-rate mode logic of the memory device: holds the temperature and
  granularity mode fields, executes or skips incoming refreshes, times the
  refresh cycle and exposes status over APB.
  Assumes the command bus is synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module rrm_top (
  input  wire logic              clk_sys_i,
  input  wire logic              reset_n_i,
  input  wire rrm_pkg::rrm_cmd_s cmd_i,
  output logic                   refresh_exec_o,
  output rrm_pkg::rrm_ref_type_e refresh_type_o,
  output logic                   refresh_busy_o,
  output logic [15:0]            interval_ns_o,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr
);
  import rrm_pkg::*;

  logic          is_mrw;
  logic          is_ref;
  logic [2:0]    mr_sel;
  logic          rate_sel;

  rrm_cmd_decode u_dec (
    .cmd_i      (cmd_i),
    .is_mrw_o   (is_mrw),
    .is_ref_o   (is_ref),
    .mr_sel_o   (mr_sel),
    .rate_sel_o (rate_sel)
  );

  // ==========================================================
  // mode registers
  logic        tcomp_en, next_tcomp_en;
  logic        tcomp_ext, next_tcomp_ext;
  logic [2:0]  gran, next_gran;
  logic [15:0] next_interval;

  always_comb begin
    next_tcomp_en  = tcomp_en;
    next_tcomp_ext = tcomp_ext;
    next_gran      = gran;
    if (is_mrw && mr_sel == MR_SEL_TEMP) begin
      next_tcomp_en  = cmd_i.addr[TCOMP_EN_BIT];
      next_tcomp_ext = cmd_i.addr[TCOMP_EXT_BIT];
    end
    if (is_mrw && mr_sel == MR_SEL_GRAN) begin
      next_gran = cmd_i.addr[GRAN_LSB +: 3];
    end
    // expected interval follows mode at once; fixed 2x/4x shorten it, dynamic modes keep it
    next_interval = (next_tcomp_en && next_tcomp_ext) ? REFI_EXT_NS : REFI_BASE_NS;
    case (next_gran)
      GRAN_FIX2: next_interval = next_interval >> 1;
      GRAN_FIX4: next_interval = next_interval >> 2;
      default:   next_interval = next_interval;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tcomp_en      <= 1'h0;
      tcomp_ext     <= 1'h0;
      gran          <= GRAN_RESET;
      interval_ns_o <= REFI_BASE_NS;
    end else begin
      tcomp_en      <= next_tcomp_en;
      tcomp_ext     <= next_tcomp_ext;
      gran          <= next_gran;
      interval_ns_o <= next_interval;
    end
  end

  // ==========================================================
  // refresh type, skipping and cycle timer
  logic signed [7:0] temp;
  rrm_state_e        state, next_state;
  logic [3:0]        rfc_cnt, next_rfc_cnt;
  logic [2:0]        ext_cnt, next_ext_cnt;
  logic [1:0]        skip_shift;
  logic              do_exec, next_exec;
  rrm_ref_type_e     ref_type, next_type;
  logic [15:0]       ext_refs, next_ext_refs;
  logic [15:0]       int_refs, next_int_refs;
  logic              reserved_code;

  always_comb begin
    reserved_code = !(gran inside {GRAN_FIX1, GRAN_FIX2, GRAN_FIX4, GRAN_DYN12, GRAN_DYN14});
    case (gran)
      GRAN_FIX2:  ref_type = RRM_REF_2X;
      GRAN_FIX4:  ref_type = RRM_REF_4X;
      GRAN_DYN12: ref_type = rate_sel ? RRM_REF_2X : RRM_REF_1X;
      GRAN_DYN14: ref_type = rate_sel ? RRM_REF_4X : RRM_REF_1X;
      default:    ref_type = RRM_REF_1X;
    endcase
    // gear ratio: execute one refresh per 2**skip_shift; hot parts skip none
    skip_shift = 2'h0;
    if (tcomp_en && gran == GRAN_FIX1) begin
      if (!tcomp_ext) begin
        skip_shift = (temp < TEMP_COLD_C) ? 2'h2 : 2'h0;
      end else if (temp < TEMP_COLD_C) begin
        skip_shift = 2'h3;
      end else if (temp <= TEMP_HOT_C) begin
        skip_shift = 2'h1;
      end
    end
    next_state    = state;
    next_rfc_cnt  = rfc_cnt;
    next_ext_cnt  = ext_cnt;
    next_exec     = 1'h0;
    next_type     = refresh_type_o;
    next_ext_refs = ext_refs;
    next_int_refs = int_refs;
    case (state)
      RRM_ST_IDLE: begin
        if (is_ref) begin
          next_ext_refs = ext_refs + 16'h1;
          next_ext_cnt  = ext_cnt + 3'h1;
          // skipping is decided here alone, with no extra signalling
          if ((ext_cnt & ((3'h1 << skip_shift) - 3'h1)) == 3'h0) begin
            next_exec     = 1'h1;
            next_type     = ref_type;
            next_int_refs = int_refs + 16'h1;
            next_state    = RRM_ST_BUSY;
            case (ref_type)
              RRM_REF_2X: next_rfc_cnt = RFC2_CYC;
              RRM_REF_4X: next_rfc_cnt = RFC4_CYC;
              default:    next_rfc_cnt = RFC1_CYC;
            endcase
          end
        end
      end
      RRM_ST_BUSY: begin
        next_rfc_cnt = rfc_cnt - 4'h1;
        if (rfc_cnt == 4'h1) begin
          next_state = RRM_ST_IDLE;
        end
      end
      default: next_state = RRM_ST_IDLE;
    endcase
    if (is_mrw && mr_sel == MR_SEL_TEMP) begin
      next_ext_cnt = 3'h0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state          <= RRM_ST_IDLE;
      rfc_cnt        <= 4'h0;
      ext_cnt        <= 3'h0;
      refresh_exec_o <= 1'h0;
      refresh_type_o <= RRM_REF_1X;
      ext_refs       <= 16'h0;
      int_refs       <= 16'h0;
    end else begin
      state          <= next_state;
      rfc_cnt        <= next_rfc_cnt;
      ext_cnt        <= next_ext_cnt;
      refresh_exec_o <= next_exec;
      refresh_type_o <= next_type;
      ext_refs       <= next_ext_refs;
      int_refs       <= next_int_refs;
    end
  end

  assign refresh_busy_o = (state == RRM_ST_BUSY);

  // ==========================================================
  // APB slave, zero wait states
  logic [2:0]  flags, next_flags;
  logic signed [7:0] next_temp;
  logic [31:0] next_prdata;
  logic        wr_en;
  logic        rd_hit;

  always_comb begin
    wr_en       = psel && penable && pwrite;
    rd_hit      = 1'h1;
    next_temp   = temp;
    next_flags  = flags;
    next_prdata = 32'h0;
    case (paddr)
      OFS_STATUS:   next_prdata = {24'h0, refresh_type_o, refresh_busy_o, tcomp_ext, tcomp_en, gran};
      OFS_TEMP:     next_prdata = {24'h0, temp};
      OFS_FLAGS:    next_prdata = {29'h0, flags};
      OFS_COUNT:    next_prdata = {int_refs, ext_refs};
      OFS_INTERVAL: next_prdata = {16'h0, interval_ns_o};
      default:      rd_hit      = 1'h0;
    endcase
    if (wr_en && paddr == OFS_TEMP) begin
      next_temp = pwdata[7:0];
    end
    if (wr_en && paddr == OFS_FLAGS) begin
      next_flags = flags & ~pwdata[2:0];
    end
    // events set after the clear so a same-cycle event is kept
    if (is_ref && state == RRM_ST_BUSY) begin
      next_flags[FLG_BUSY_VIOL] = 1'h1;
    end
    if (reserved_code) begin
      next_flags[FLG_RESERVED] = 1'h1;
    end
    if (tcomp_en && gran != GRAN_FIX1) begin
      next_flags[FLG_TCOMP_CONF] = 1'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      temp   <= TEMP_RESET;
      flags  <= 3'h0;
      prdata <= 32'h0;
    end else begin
      temp   <= next_temp;
      flags  <= next_flags;
      prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  // ==========================================================
  // checks
  logic [3:0] skip_run;
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      skip_run <= 4'h0;
    end else if (refresh_exec_o) begin
      skip_run <= 4'h0;
    end else if (is_ref && state == RRM_ST_IDLE && !next_exec) begin
      skip_run <= skip_run + 4'h1;
    end
  end

  a_temp_mode_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    is_mrw && mr_sel == MR_SEL_TEMP
    |=> tcomp_en == $past(cmd_i.addr[TCOMP_EN_BIT]) && tcomp_ext == $past(cmd_i.addr[TCOMP_EXT_BIT]))
    else $error("temperature mode bits not taken");
  a_skip_normal: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    tcomp_en && !tcomp_ext && is_ref && state == RRM_ST_IDLE && skip_run == 4'h3 |=> refresh_exec_o)
    else $error("more than three of four refreshes skipped");
  a_skip_extended: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    skip_run <= 4'h7)
    else $error("more than seven of eight refreshes skipped");
  a_exec_cause: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    refresh_exec_o |-> $past(is_ref) && $past(state) == RRM_ST_IDLE)
    else $error("refresh executed without a refresh command");
  a_gran_write: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    is_mrw && mr_sel == MR_SEL_GRAN |=> gran == $past(cmd_i.addr[GRAN_LSB +: 3]))
    else $error("granularity field not taken");
  a_dyn_select: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    is_ref && state == RRM_ST_IDLE && gran == GRAN_DYN14 && skip_shift == 2'h0
    |=> refresh_type_o == ($past(rate_sel) ? RRM_REF_4X : RRM_REF_1X))
    else $error("dynamic rate select misread");
  a_fixed_single: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    refresh_exec_o && $past(gran) == GRAN_FIX1 |-> refresh_type_o == RRM_REF_1X)
    else $error("fixed 1x produced another refresh type");
  a_cycle_1x: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    refresh_exec_o && refresh_type_o == RRM_REF_1X |-> refresh_busy_o [*4] ##1 !refresh_busy_o)
    else $error("1x refresh cycle time wrong");
  a_cycle_2x: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    refresh_exec_o && refresh_type_o == RRM_REF_2X |-> refresh_busy_o [*3] ##1 !refresh_busy_o)
    else $error("2x refresh cycle time wrong");
  a_cycle_4x: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    refresh_exec_o && refresh_type_o == RRM_REF_4X |-> refresh_busy_o [*2] ##1 !refresh_busy_o)
    else $error("4x refresh cycle time wrong");
  a_interval_now: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    is_mrw && mr_sel == MR_SEL_GRAN && cmd_i.addr[GRAN_LSB +: 3] == GRAN_FIX2 && !tcomp_en
    |=> interval_ns_o == (REFI_BASE_NS >> 1))
    else $error("interval not updated at mode change");

endmodule

/* verif/rrm_ctrl_model.sv */
/*
  Controller model: drives mode register writes and refreshes on the
  command bus, one command at a time.
  Assumes the bench calls its tasks from a single process.
*/
`timescale 1ns/1ps
module rrm_ctrl_model (
  input  wire logic        clk_i,
  output rrm_pkg::rrm_cmd_s cmd_o
);
  import rrm_pkg::*;

  initial cmd_o = '1;

  // ====================
  // command issue
  // a command stands one cycle; on deselect the other lines flip so that
  // a decoder that ignores the chip select cannot live off stale values
  task automatic send(input rrm_cmd_s c);
    @(posedge clk_i);
    cmd_o <= c;
    @(posedge clk_i);
    cmd_o <= {1'h1, ~c[21:0]};
  endtask

  task automatic mr_write(input logic [2:0] s, input logic [13:0] a);
    send('{1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, s[2], s[1:0], a});
  endtask

  // rate select rides on its own bit, only looked at in the dynamic modes
  task automatic refresh(input logic r);
    send('{1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, r, 2'h0, 14'h0});
  endtask
endmodule

/* verif/testbench.sv */
/*
  Self-checking bench of the refresh-rate mode logic: reset values, register
  access and refused accesses, then mode table loop, busy refresh and second reset.
  Assumes rrm_top with zero-wait APB and the controller model on its bus.
*/
`timescale 1ns/1ps
module testbench;
  import rrm_pkg::*;

  typedef struct {
    logic [2:0]    gran;
    logic [1:0]    tcomp;
    logic [7:0]    temp;
    logic          sel;
    rrm_ref_type_e typ;
    logic [15:0]   ivl;
    logic [15:0]   execs;
  } rrm_row_s;

  logic          clk_sys_i = 1'h0;
  logic          reset_n_i = 1'h0;
  logic          psel = 1'h0;
  logic          penable = 1'h0;
  logic          pwrite = 1'h0;
  logic [7:0]    paddr = 8'h0;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata, q, c0;
  logic          pready, pslverr, e, refresh_exec_o, refresh_busy_o;
  logic [15:0]   interval_ns_o;
  rrm_ref_type_e refresh_type_o;
  rrm_cmd_s      cmd_i;
  int            error_cnt = 0;
  int            checks = 0;
  int            execs = 0;
  int            blen = 0;

  // ====================
  // mode table: granularity, {enable, extended}, temperature, select,
  // expected type, interval and executed refreshes out of eight
  rrm_row_s rows[14] = '{
    '{3'h0, 2'h0, 8'h19, 1'h0, RRM_REF_1X, 16'h1e78, 16'h8},
    '{3'h1, 2'h0, 8'h19, 1'h1, RRM_REF_2X, 16'h0f3c, 16'h8},
    '{3'h2, 2'h0, 8'h19, 1'h1, RRM_REF_4X, 16'h079e, 16'h8},
    '{3'h5, 2'h0, 8'h19, 1'h0, RRM_REF_1X, 16'h1e78, 16'h8},
    '{3'h5, 2'h0, 8'h19, 1'h1, RRM_REF_2X, 16'h1e78, 16'h8},
    '{3'h6, 2'h0, 8'h19, 1'h0, RRM_REF_1X, 16'h1e78, 16'h8},
    '{3'h6, 2'h0, 8'h19, 1'h1, RRM_REF_4X, 16'h1e78, 16'h8},
    '{3'h0, 2'h2, 8'h2c, 1'h0, RRM_REF_1X, 16'h1e78, 16'h2},
    '{3'h0, 2'h2, 8'h2d, 1'h0, RRM_REF_1X, 16'h1e78, 16'h8},
    '{3'h0, 2'h3, 8'h2c, 1'h0, RRM_REF_1X, 16'h0f3c, 16'h1},
    '{3'h0, 2'h3, 8'h2d, 1'h0, RRM_REF_1X, 16'h0f3c, 16'h4},
    '{3'h0, 2'h3, 8'h55, 1'h0, RRM_REF_1X, 16'h0f3c, 16'h4},
    '{3'h0, 2'h3, 8'h56, 1'h0, RRM_REF_1X, 16'h0f3c, 16'h8},
    '{3'h3, 2'h0, 8'h19, 1'h1, RRM_REF_1X, 16'h1e78, 16'h8}
  };

  rrm_top i_dut (.clk_sys_i, .reset_n_i, .cmd_i, .refresh_exec_o, .refresh_type_o, .refresh_busy_o,
                 .interval_ns_o, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  rrm_ctrl_model i_ctrl (.clk_i(clk_sys_i), .cmd_o(cmd_i));

  always #50 clk_sys_i = ~clk_sys_i;

  // ====================
  // checking and bus tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'h1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) begin
      chk(32'h0, 32'h1);
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q, x);
  endtask

  // busy length is judged against the type of the refresh that started it
  always @(posedge clk_sys_i) begin
    if (refresh_exec_o === 1'h1) execs++;
    if (refresh_busy_o === 1'h1) blen++;
    else if (blen != 0) begin
      chk(32'(blen), 32'(refresh_type_o == RRM_REF_1X ? RFC1_CYC :
          refresh_type_o == RRM_REF_2X ? RFC2_CYC : RFC4_CYC));
      blen = 0;
    end
  end

  // ====================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    chk(32'({refresh_exec_o, refresh_busy_o, refresh_type_o, interval_ns_o}), 32'h1e78);
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_TEMP, 32'(TEMP_RESET));
    rdc(OFS_FLAGS, 32'h0);
    rdc(OFS_COUNT, 32'h0);
    $display("test reset done");
    apb(1'h1, OFS_TEMP, 32'h2c);
    rdc(OFS_TEMP, 32'h2c);
    apb(1'h1, OFS_INTERVAL, 32'h0);
    rdc(OFS_INTERVAL, 32'h1e78);
    rdc(8'h14, 32'h0);
    chk(32'(e), 32'h1);
    apb(1'h1, 8'h14, 32'hff);
    chk(32'(e), 32'h1);
    $display("test registers done");
    foreach (rows[i]) begin
      apb(1'h1, OFS_TEMP, 32'(rows[i].temp));
      i_ctrl.mr_write(MR_SEL_TEMP, 14'h0);
      i_ctrl.mr_write(MR_SEL_GRAN, 14'(rows[i].gran) << GRAN_LSB);
      i_ctrl.mr_write(MR_SEL_TEMP, 14'(rows[i].tcomp) << TCOMP_EXT_BIT);
      @(negedge clk_sys_i);
      chk(32'(interval_ns_o), 32'(rows[i].ivl));
      apb(1'h0, OFS_COUNT, 32'h0);
      c0 = q;
      execs = 0;
      // eight keeps whole skip groups of one in two, four and eight refreshes
      repeat (8) begin
        i_ctrl.refresh(rows[i].sel);
        repeat (5) @(posedge clk_sys_i);
      end
      rdc(OFS_COUNT, c0 + {rows[i].execs, 16'h8});
      chk(32'(execs), 32'(rows[i].execs));
      chk(32'(refresh_type_o), 32'(rows[i].typ));
      rdc(OFS_STATUS, {24'h0, rows[i].typ, 1'h0, rows[i].tcomp[0], rows[i].tcomp[1], rows[i].gran});
      $display("test row %0d done", i);
    end
    rdc(OFS_FLAGS, 32'h2);
    i_ctrl.mr_write(MR_SEL_GRAN, 14'h0);
    apb(1'h1, OFS_FLAGS, 32'h7);
    rdc(OFS_FLAGS, 32'h0);
    apb(1'h0, OFS_COUNT, 32'h0);
    c0 = q;
    i_ctrl.refresh(1'h0);
    i_ctrl.refresh(1'h0);
    repeat (6) @(posedge clk_sys_i);
    rdc(OFS_COUNT, c0 + 32'h10001);
    rdc(OFS_FLAGS, 32'h1);
    apb(1'h1, OFS_FLAGS, 32'h1);
    rdc(OFS_FLAGS, 32'h0);
    $display("test busy refresh done");
    i_ctrl.mr_write(MR_SEL_GRAN, 14'(GRAN_FIX2) << GRAN_LSB);
    i_ctrl.mr_write(MR_SEL_TEMP, 14'h8);
    rdc(OFS_FLAGS, 32'h4);
    reset_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'h1;
    rdc(OFS_STATUS, 32'h0);
    rdc(OFS_INTERVAL, 32'h1e78);
    $display("test second reset done");
    report_and_stop();
  end
endmodule
